// ---- hw/osc_ctrl_pkg.sv ----
// constants, types and field layout for the oscillator control block
// Contract
// RULE_01: writes refused unless the byte's unlock sequence came just before.
// RULE_02: software never switches directly between the two pll based sources.
// RULE_03: between pll sources software passes through plain fast rc first.
// RULE_04: writing one to the fail flag acts as a real failure and traps; the code traps only if the flag was clear and keeps the current source.
// RULE_05: software should write the fail flag only to clear it.
// RULE_06: select code 101 is low power rc, 110 is backup fast rc.
// RULE_07: reserved select code 100 is treated as fast rc.
// RULE_08: unimplemented bits read zero and ignore writes.
// RULE_09: pll lock bit reads one only when enabled, settled and locked.
// RULE_10: current source field shows the active source after each switch.
// RULE_11: freeze bit with monitor config one blocks source and pll changes.
// RULE_12: switch request starts a change and clears itself when complete.
// RULE_13: fail flag is set when the monitor detects a main clock failure.
// RULE_14: upper byte unlock is 0x78 then 0x9A, then the modifying write.
// RULE_15: lower byte unlock is 0x46 then 0x57, then the modifying write.
`default_nettype none
package osc_ctrl_pkg;
    localparam logic [31:0] OSC_CONTROL_ADDR = 32'h0000_0000;
    localparam logic [31:0] OSC_STATUS_ADDR = 32'h0000_0004;
    localparam int CUR_SRC_LSB = 12;
    localparam int NEW_SRC_LSB = 8;
    localparam int FREEZE_BIT = 7;
    localparam int LOCK_BIT = 5;
    localparam int FAIL_BIT = 3;
    localparam int SWITCH_BIT = 0;
    localparam logic [15:0] CTRL_IMPL_MASK = 16'h77A9;
    localparam logic [7:0] HI_KEY1 = 8'h78;
    localparam logic [7:0] HI_KEY2 = 8'h9A;
    localparam logic [7:0] LO_KEY1 = 8'h46;
    localparam logic [7:0] LO_KEY2 = 8'h57;
    localparam logic [2:0] SRC_FRC = 3'h0;
    localparam logic [2:0] SRC_RESERVED = 3'h4;
    localparam logic [2:0] SRC_LOW_POWER_RC_OSC = 3'h5;
    localparam logic [2:0] SRC_BACKUP_FAST_RC_OSC = 3'h6;
    localparam logic [2:0] SRC_RESET = 3'h0;
    localparam logic [2:0] SWITCH_WAIT_RESET = 3'h0;

    typedef struct packed {
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] haddr;
    } ahb_addr_t;

    typedef enum logic [1:0] {KEY_IDLE, KEY_ONE, KEY_OPEN} unlock_t;

    // fold the reserved code onto fast rc
    function automatic logic [2:0] map_source(input logic [2:0] code);
        map_source = (code == SRC_RESERVED) ? SRC_FRC : code;
    endfunction : map_source
endpackage : osc_ctrl_pkg
`default_nettype wire

// ---- hw/oscillator_select_control.sv ----
// oscillator control register with byte unlock, source switching and fail flag
`default_nettype none
module oscillator_select_control
    import osc_ctrl_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic [31:0] hrdata_out,
    input wire logic fail_monitor_cfg_bit_in,
    input wire logic fail_detect_in,
    input wire logic switch_done_in,
    input wire logic pll_enabled_in,
    input wire logic pll_locked_in,
    input wire logic pll_timer_busy_in,
    output logic [2:0] source_request_out,
    output logic switch_start_out,
    output logic osc_fail_trap_out
);
    ahb_addr_t aph_reg, aph_next;
    logic dph_reg, dph_next;
    unlock_t hi_state_reg, hi_state_next, lo_state_reg, lo_state_next;
    logic [2:0] cur_src_reg, cur_src_next, new_src_reg, new_src_next;
    logic freeze_reg, freeze_next, fail_reg, fail_next;
    logic switch_reg, switch_next, trap_reg, trap_next, start_reg, start_next;
    logic [31:0] rdata_reg, rdata_next;
    logic sync_fail_1_reg, sync_fail_2_reg, fail_seen_reg;
    logic sync_done_1_reg, sync_done_2_reg;
    logic sync_lk_1_reg, sync_lk_2_reg, sync_en_1_reg, sync_en_2_reg;
    logic sync_tm_1_reg, sync_tm_2_reg, sync_cfg_1_reg, sync_cfg_2_reg;
    logic wr_ctrl, hi_lane, lo_lane, hi_open, lo_open, frozen, fail_rise;
    logic pll_lock_bit;
    logic [15:0] ctrl_view;

    // external levels cross two flip-flops before use
    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            sync_fail_1_reg <= 1'b0;
            sync_fail_2_reg <= 1'b0;
            fail_seen_reg <= 1'b0;
            sync_done_1_reg <= 1'b0;
            sync_done_2_reg <= 1'b0;
            sync_lk_1_reg <= 1'b0;
            sync_lk_2_reg <= 1'b0;
            sync_en_1_reg <= 1'b0;
            sync_en_2_reg <= 1'b0;
            sync_tm_1_reg <= 1'b0;
            sync_tm_2_reg <= 1'b0;
            sync_cfg_1_reg <= 1'b0;
            sync_cfg_2_reg <= 1'b0;
        end
        else
        begin
            sync_fail_1_reg <= fail_detect_in;
            sync_fail_2_reg <= sync_fail_1_reg;
            fail_seen_reg <= sync_fail_2_reg;
            sync_done_1_reg <= switch_done_in;
            sync_done_2_reg <= sync_done_1_reg;
            sync_lk_1_reg <= pll_locked_in;
            sync_lk_2_reg <= sync_lk_1_reg;
            sync_en_1_reg <= pll_enabled_in;
            sync_en_2_reg <= sync_en_1_reg;
            sync_tm_1_reg <= pll_timer_busy_in;
            sync_tm_2_reg <= sync_tm_1_reg;
            sync_cfg_1_reg <= fail_monitor_cfg_bit_in;
            sync_cfg_2_reg <= sync_cfg_1_reg;
        end
    end

    assign fail_rise = sync_fail_2_reg && !fail_seen_reg;
    assign pll_lock_bit = sync_en_2_reg && !sync_tm_2_reg
        && sync_lk_2_reg; // [RULE_09]
    assign frozen = freeze_reg && sync_cfg_2_reg; // [RULE_11]
    assign wr_ctrl = dph_reg && aph_reg.hwrite
        && {aph_reg.haddr[31:2], 2'b00} == OSC_CONTROL_ADDR;
    assign hi_lane = aph_reg.hsize == 3'h2
        || (aph_reg.hsize == 3'h1 && !aph_reg.haddr[1] && aph_reg.haddr[0])
        || (aph_reg.hsize == 3'h0 && aph_reg.haddr[1:0] == 2'h1)
        || (aph_reg.hsize == 3'h1 && aph_reg.haddr[1:0] == 2'h0);
    assign lo_lane = aph_reg.hsize == 3'h2
        || (aph_reg.hsize == 3'h1 && aph_reg.haddr[1:0] == 2'h0)
        || (aph_reg.hsize == 3'h0 && aph_reg.haddr[1:0] == 2'h0);
    assign hi_open = hi_state_reg == KEY_OPEN; // [RULE_01]
    assign lo_open = lo_state_reg == KEY_OPEN; // [RULE_01]
    assign ctrl_view = {1'b0, cur_src_reg, 1'b0, new_src_reg, freeze_reg,
        1'b0, pll_lock_bit, 1'b0, fail_reg, 2'b00, switch_reg}
        & CTRL_IMPL_MASK; // [RULE_08]

    // key sequencer per byte: any other write to the byte rearms it
    function automatic unlock_t key_step(input unlock_t st,
        input logic hit, input logic [7:0] d,
        input logic [7:0] k1, input logic [7:0] k2);
        unlock_t nx;
        nx = st;
        if (hit)
        begin
            unique case (st)
                KEY_IDLE: nx = (d == k1) ? KEY_ONE : KEY_IDLE;
                KEY_ONE: nx = (d == k2) ? KEY_OPEN : (d == k1 ? KEY_ONE
                    : KEY_IDLE);
                KEY_OPEN: nx = KEY_IDLE;
                default: nx = KEY_IDLE;
            endcase
        end
        key_step = nx;
    endfunction : key_step

    always_comb
    begin
        aph_next = aph_reg;
        dph_next = 1'b0;
        if (hready_in)
        begin
            aph_next = '{htrans: htrans_in, hwrite: hwrite_in,
                hsize: hsize_in, haddr: {haddr_in[31:2], 2'b00}
                | {30'h0, haddr_in[1:0]}};
            dph_next = hsel_in && htrans_in[1];
        end
        hi_state_next = key_step(hi_state_reg, wr_ctrl && hi_lane,
            hwdata_in[15:8], HI_KEY1, HI_KEY2); // [RULE_14]
        lo_state_next = key_step(lo_state_reg, wr_ctrl && lo_lane,
            hwdata_in[7:0], LO_KEY1, LO_KEY2); // [RULE_15]
        cur_src_next = cur_src_reg;
        new_src_next = new_src_reg;
        freeze_next = freeze_reg;
        fail_next = fail_reg;
        switch_next = switch_reg;
        start_next = 1'b0;
        trap_next = 1'b0;
        if (wr_ctrl && hi_lane && hi_open && !frozen) // [RULE_01] [RULE_11]
            new_src_next = map_source(hwdata_in[10:8]); // [RULE_06] [RULE_07]
        if (wr_ctrl && lo_lane && lo_open) // [RULE_01]
        begin
            freeze_next = freeze_reg | hwdata_in[FREEZE_BIT];
            fail_next = hwdata_in[FAIL_BIT];
            if (hwdata_in[FAIL_BIT] && !fail_reg)
                trap_next = 1'b1; // [RULE_04]
            if (hwdata_in[SWITCH_BIT] && !switch_reg && !frozen)
            begin
                switch_next = 1'b1; // [RULE_12]
                start_next = 1'b1;
            end
        end
        if (switch_reg && sync_done_2_reg)
        begin
            switch_next = 1'b0; // [RULE_12]
            cur_src_next = new_src_reg; // [RULE_10]
        end
        if (fail_rise)
        begin
            fail_next = 1'b1; // [RULE_13]
            trap_next = 1'b1;
            cur_src_next = SRC_BACKUP_FAST_RC_OSC;
        end
        rdata_next = 32'h0000_0000;
        if (hready_in && hsel_in && htrans_in[1] && !hwrite_in)
        begin
            if ({haddr_in[31:2], 2'b00} == OSC_CONTROL_ADDR)
                rdata_next = {16'h0000, ctrl_view};
            else if ({haddr_in[31:2], 2'b00} == OSC_STATUS_ADDR)
                rdata_next = {24'h0, 5'h0, hi_open, lo_open, frozen};
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            aph_reg <= '0;
            dph_reg <= 1'b0;
            hi_state_reg <= KEY_IDLE;
            lo_state_reg <= KEY_IDLE;
            cur_src_reg <= SRC_RESET;
            new_src_reg <= SRC_RESET;
            freeze_reg <= 1'b0;
            fail_reg <= 1'b0;
            switch_reg <= 1'b0;
            start_reg <= 1'b0;
            trap_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end
        else
        begin
            aph_reg <= aph_next;
            dph_reg <= dph_next;
            hi_state_reg <= hi_state_next;
            lo_state_reg <= lo_state_next;
            cur_src_reg <= cur_src_next;
            new_src_reg <= new_src_next;
            freeze_reg <= freeze_next;
            fail_reg <= fail_next;
            switch_reg <= switch_next;
            start_reg <= start_next;
            trap_reg <= trap_next;
            rdata_reg <= rdata_next;
        end
    end

    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign hrdata_out = rdata_reg;
    assign source_request_out = new_src_reg;
    assign switch_start_out = start_reg;
    assign osc_fail_trap_out = trap_reg;

    sequence hi_arm_s;
        wr_ctrl && hi_lane && !hi_open && hwdata_in[15:8] == HI_KEY1;
    endsequence

    sequence hi_key_s;
        hi_state_reg == KEY_ONE && wr_ctrl && hi_lane
            && hwdata_in[15:8] == HI_KEY2;
    endsequence

    sequence lo_arm_s;
        wr_ctrl && lo_lane && !lo_open && hwdata_in[7:0] == LO_KEY1;
    endsequence

    sequence lo_key_s;
        lo_state_reg == KEY_ONE && wr_ctrl && lo_lane
            && hwdata_in[7:0] == LO_KEY2;
    endsequence

    locked_write_a: assert property (@(posedge sys_clk_in) // [RULE_01]
        disable iff (!reset_n_in)
        wr_ctrl && hi_lane && !hi_open |=> $stable(new_src_reg))
        else $error("source select changed without unlock");
    hi_arm_a: assert property (@(posedge sys_clk_in) // [RULE_14]
        disable iff (!reset_n_in)
        hi_arm_s |=> hi_state_reg == KEY_ONE)
        else $error("upper byte first key not taken");
    hi_unlock_a: assert property (@(posedge sys_clk_in) // [RULE_14]
        disable iff (!reset_n_in)
        hi_key_s |=> hi_open)
        else $error("upper byte keys did not open the byte");
    lo_arm_a: assert property (@(posedge sys_clk_in) // [RULE_15]
        disable iff (!reset_n_in)
        lo_arm_s |=> lo_state_reg == KEY_ONE)
        else $error("lower byte first key not taken");
    lo_unlock_a: assert property (@(posedge sys_clk_in) // [RULE_15]
        disable iff (!reset_n_in)
        lo_key_s |=> lo_open)
        else $error("lower byte keys did not open the byte");
    trap_on_write_a: assert property (@(posedge sys_clk_in) // [RULE_04]
        disable iff (!reset_n_in)
        wr_ctrl && lo_lane && lo_open && hwdata_in[FAIL_BIT] && !fail_reg
        |=> osc_fail_trap_out && fail_reg)
        else $error("fail flag write did not trap");
    trap_flag_a: assert property (@(posedge sys_clk_in) // [RULE_04]
        disable iff (!reset_n_in)
        osc_fail_trap_out |-> fail_reg)
        else $error("trap raised without fail flag");
    src_store_a: assert property (@(posedge sys_clk_in) // [RULE_06]
        disable iff (!reset_n_in)
        wr_ctrl && hi_lane && hi_open && !frozen
        && hwdata_in[NEW_SRC_LSB +: 3] != SRC_RESERVED
        |=> new_src_reg == $past(hwdata_in[NEW_SRC_LSB +: 3]))
        else $error("new source code not stored");
    reserved_map_a: assert property (@(posedge sys_clk_in) // [RULE_07]
        disable iff (!reset_n_in)
        new_src_reg != SRC_RESERVED)
        else $error("reserved source code stored");
    unimpl_zero_a: assert property (@(posedge sys_clk_in) // [RULE_08]
        disable iff (!reset_n_in)
        dph_reg && !aph_reg.hwrite
        && {aph_reg.haddr[31:2], 2'b00} == OSC_CONTROL_ADDR
        |-> (hrdata_out & ~{16'h0000, CTRL_IMPL_MASK}) == 32'h0000_0000)
        else $error("unimplemented bit reads nonzero");
    pll_lock_a: assert property (@(posedge sys_clk_in) // [RULE_09]
        disable iff (!reset_n_in)
        !sync_en_2_reg || sync_tm_2_reg || !sync_lk_2_reg
        |-> !ctrl_view[LOCK_BIT])
        else $error("lock bit set while pll not ready");
    switch_done_a: assert property ( // [RULE_10] [RULE_12]
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        switch_reg && sync_done_2_reg && !fail_rise
        |=> !switch_reg && cur_src_reg == $past(new_src_reg))
        else $error("switch completion not reflected");
    freeze_block_a: assert property (@(posedge sys_clk_in) // [RULE_11]
        disable iff (!reset_n_in)
        frozen && !switch_reg |=> !switch_reg)
        else $error("switch started while frozen");
    freeze_hold_a: assert property (@(posedge sys_clk_in) // [RULE_11]
        disable iff (!reset_n_in)
        freeze_reg |=> freeze_reg)
        else $error("freeze bit cleared without reset");
    fail_set_a: assert property (@(posedge sys_clk_in) // [RULE_13]
        disable iff (!reset_n_in)
        fail_rise |=> fail_reg && cur_src_reg == SRC_BACKUP_FAST_RC_OSC)
        else $error("monitor failure not flagged");
    start_pulse_a: assert property (@(posedge sys_clk_in) // [RULE_12]
        disable iff (!reset_n_in)
        switch_start_out |-> switch_reg ##1 !switch_start_out)
        else $error("switch start pulse malformed");
endmodule : oscillator_select_control
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the oscillator control register block
`default_nettype none
module testbench
    import osc_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_ph = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2, src_req, cur = 3'h0, nsel = 3'h0;
    logic hready, hresp, start, trap;
    logic cfg = 1'b0, fdet = 1'b0, sdone = 1'b0, pen = 1'b0, plk = 1'b0;
    logic pbusy = 1'b0, frz = 1'b0, fail = 1'b0, sw = 1'b0, lk = 1'b0;
    logic [31:0] exp_q[$];
    logic [15:0] rnd = 16'h0060;
    int err_total = 0, num_checks = 0, n_start = 0, n_trap = 0;

    oscillator_select_control dut (.sys_clk_in(clk), .reset_n_in(rst_n),
        .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
        .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
        .hready_in(hready), .hreadyout_out(hready), .hresp_out(hresp),
        .hrdata_out(hrdata), .fail_monitor_cfg_bit_in(cfg),
        .fail_detect_in(fdet), .switch_done_in(sdone),
        .pll_enabled_in(pen), .pll_locked_in(plk),
        .pll_timer_busy_in(pbusy), .source_request_out(src_req),
        .switch_start_out(start), .osc_fail_trap_out(trap));

    initial forever #5 clk = ~clk;

    function automatic logic [15:0] xs(input logic [15:0] x);
        x = x ^ (x << 7);
        x = x ^ (x >> 9);
        xs = x ^ (x << 8);
    endfunction : xs

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        num_checks++;
        if (got !== want)
        begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time,
                got, want);
        end
    endtask : chk

    task automatic report_and_stop();
        if (exp_q.size() != 0)
            err_total++;
        if (err_total == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop

    // one aligned word transfer; read data is judged by the watcher
    task automatic bus(input logic wr, input logic [31:0] a,
        input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        rd_ph <= ~wr;
        do @(posedge clk); while (hready !== 1'b1);
        rd_ph <= 1'b0;
        chk({31'h0, hresp}, 32'h0);
    endtask : bus

    function automatic logic [31:0] ctl();
        ctl = {16'h0, 1'b0, cur, 1'b0, nsel, frz, 1'b0, lk, 1'b0, fail,
            2'b0, sw};
    endfunction : ctl

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rd

    task automatic unl();
        bus(1'b1, 32'h0, 32'h0000_7846);
        bus(1'b1, 32'h0, 32'h0000_9A57);
    endtask : unl

    task automatic waitc(input int n);
        repeat (n) @(posedge clk);
    endtask : waitc

    always @(posedge clk)
    begin
        if (start === 1'b1) n_start++;
        if (trap === 1'b1) n_trap++;
        if (rd_ph && hready === 1'b1 && exp_q.size() > 0)
            chk(hrdata, exp_q.pop_front());
    end

    initial
    begin
        #200us;
        err_total++;
        report_and_stop();
    end

    initial
    begin
        logic [7:0] up;
        waitc(16);
        rst_n <= 1'b1;
        rd(32'h0, ctl());
        rd(32'h10, 32'h0);
        bus(1'b1, 32'h0, 32'h0000_0500);
        rd(32'h0, ctl());
        bus(1'b1, 32'h0, 32'h0000_9A57);
        bus(1'b1, 32'h0, 32'h0000_7846);
        bus(1'b1, 32'h0, 32'h0000_0500);
        rd(32'h0, ctl());
        for (int i = 0; i < 8; i++)
        begin
            rnd = xs(rnd);
            up = {rnd[7:3], 3'(i)};
            unl();
            bus(1'b1, 32'h0, {rnd, up, rnd[15:8] & 8'h76});
            nsel = (i == 4) ? 3'h0 : 3'(i);
            rd(32'h0, ctl());
        end
        bus(1'b1, 32'h0, 32'h0);
        rd(32'h0, ctl());
        unl();
        bus(1'b1, 32'h0, 32'h0000_0500);
        nsel = 3'h5;
        unl();
        bus(1'b1, 32'h0, 32'h0000_0501);
        sw = 1'b1;
        waitc(3);
        chk(n_start, 1);
        chk({29'h0, src_req}, 32'h5);
        rd(32'h0, ctl());
        sdone <= 1'b1;
        waitc(5);
        sdone <= 1'b0;
        sw = 1'b0;
        cur = 3'h5;
        rd(32'h0, ctl());
        for (int i = 0; i < 8; i++)
        begin
            {pen, plk, pbusy} <= (i == 7) ? 3'b110 : 3'(i);
            waitc(5);
            lk = (i == 6 || i == 7);
            rd(32'h0, ctl());
        end
        unl();
        bus(1'b1, 32'h0, 32'h0000_0508);
        fail = 1'b1;
        waitc(3);
        chk(n_trap, 1);
        rd(32'h0, ctl());
        unl();
        bus(1'b1, 32'h0, 32'h0000_0500);
        fail = 1'b0;
        rd(32'h0, ctl());
        fdet <= 1'b1;
        waitc(6);
        fail = 1'b1;
        cur = SRC_BACKUP_FAST_RC_OSC;
        rd(32'h0, ctl());
        chk(n_trap, 2);
        fdet <= 1'b0;
        unl();
        bus(1'b1, 32'h0, 32'h0000_0580);
        fail = 1'b0;
        frz = 1'b1;
        unl();
        bus(1'b1, 32'h0, 32'h0000_0680);
        nsel = 3'h6;
        rd(32'h0, ctl());
        rd(32'h4, 32'h0);
        cfg <= 1'b1;
        waitc(5);
        unl();
        bus(1'b1, 32'h0, 32'h0000_0181);
        rd(32'h0, ctl());
        rd(32'h4, 32'h1);
        waitc(3);
        chk(n_start, 1);
        rst_n <= 1'b0;
        waitc(2);
        rst_n <= 1'b1;
        {cur, nsel, frz, fail} = 8'h00;
        waitc(4);
        rd(32'h0, ctl());
        rd(32'h4, 32'h0);
        chk({29'h0, src_req}, 32'h0);
        waitc(4);
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
